/* File: serial_cfg_pkg.sv */
package serial_cfg_pkg;
  // register byte offsets
  localparam logic [11:0] CFG0_OFS    = 12'h108;
  localparam logic [11:0] FLAG_OFS    = 12'h110;
  localparam logic [11:0] IRQ_EN_OFS  = 12'h114;
  localparam logic [11:0] IRQ_CLR_OFS = 12'h118;
  localparam logic [11:0] RX_STAT_OFS = 12'h11C;
  // config field positions, reset and writable mask
  localparam int          ENC_LSB   = 20;
  localparam int          ENG_LSB   = 16;
  localparam int          VIS_BIT   = 12;
  localparam int          BCR_BIT   = 7;
  localparam int          TOE_BIT   = 5;
  localparam logic [31:0] CFG0_RST  = 32'h0000_0000;
  localparam logic [31:0] CFG0_WMSK = 32'h0073_10A0;
  // line encodings
  localparam logic [2:0] ENC_NRZ  = 3'h0;
  localparam logic [2:0] ENC_NRZI = 3'h2;
  localparam logic [2:0] ENC_FM0  = 3'h4;
  localparam logic [2:0] ENC_FM1  = 3'h5;
  localparam logic [2:0] ENC_MAN  = 3'h6;
  // protocol engines
  localparam logic [1:0] ENG_HDLC  = 2'h0;
  localparam logic [1:0] ENG_ASYNC = 2'h3;
  // x16 oversampling: majority taps and last phase
  localparam logic [3:0] OVS_TAP0 = 4'h7;
  localparam logic [3:0] OVS_TAP1 = 4'h8;
  localparam logic [3:0] OVS_TAP2 = 4'h9;
  localparam logic [3:0] OVS_LAST = 4'hF;
  // interrupt event bits
  localparam int          EV_W      = 3;
  localparam int          EV_BIT    = 0;
  localparam int          EV_LOST   = 1;
  localparam int          EV_REGAIN = 2;
  localparam logic [2:0]  EV_RST    = 3'h0;
  // receive status layout
  localparam int RST_LOST_BIT = 8;
  localparam int RST_TXC_BIT  = 9;
  localparam int RST_ACT_BIT  = 10;
  // transmit clock generated in the output role
  localparam int          CLK_NS      = 10;
  localparam int          TXC_HALF_NS = 40;
  localparam logic [7:0]  TXC_HALF_CYC =
    8'((TXC_HALF_NS + CLK_NS - 1) / CLK_NS);
  // receiver states
  typedef enum logic [1:0] {RX_OFF, RX_SYNC, RX_LOST} rx_state_t;
endpackage

/* File: serial_channel_config_zero.sv */
`timescale 1ns/1ns
// Contract
// - encoding field 000 NRZ, 010 NRZI, 100 FM0, 101 FM1, 110 Manchester.
// - engine field 00 HDLC sync, 11 async, 01 and 10 reserved.
// - visibility bit clear hides masked flags on flag register reads.
// - visibility bit set shows masked flags; host clears by writing one.
// - masked sources never raise the interrupt output.
// - rate bit clear: async runs x1, each bit sampled once.
// - rate bit set: x16 clock, majority of three samples near centre.
// - clock-output bit sets transmit clock pin direction and transceiver.
// - reserved config bits read as zero.
// - DPLL with FM or Manchester flags sync loss, suspends, resyncs.
module serial_channel_config_zero (
  // system
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  // receive line
  input  wire logic        rx_clk,
  input  wire logic        rx_data,
  // transmit clock pin, three-signal form
  input  wire logic        tx_clk_in,
  output logic             tx_clk_out,
  output logic             tx_clk_oe_n,
  // decoded receive bits for the engine
  output logic             rx_bit,
  output logic             rx_bit_valid,
  // interrupt
  output logic             irq
);

  // decoded bit for NRZ family, from the current and previous level
  function automatic logic line_bit(input logic [2:0] enc,
                                    input logic lvl,
                                    input logic prv);
    line_bit = (enc == serial_cfg_pkg::ENC_NRZI) ? (lvl == prv) : lvl;
  endfunction

  // decoded bit for a two-half-cell code
  function automatic logic cell_bit(input logic [2:0] enc,
                                    input logic h1,
                                    input logic h2);
    case (enc)
      serial_cfg_pkg::ENC_FM0: cell_bit = (h1 == h2);
      serial_cfg_pkg::ENC_FM1: cell_bit = (h1 != h2);
      default:                 cell_bit = h1;
    endcase
  endfunction

  // mandatory transition present in a cell
  function automatic logic cell_ok(input logic [2:0] enc,
                                   input logic h1,
                                   input logic h2,
                                   input logic prev_h2);
    cell_ok = (enc == serial_cfg_pkg::ENC_MAN) ? (h1 != h2)
                                                : (h1 != prev_h2);
  endfunction

  logic [31:0] cfg_r;
  logic [2:0]  flag_r;
  logic [2:0]  flag_nxt;
  logic [2:0]  en_r;
  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic        rclk_d_r;
  logic [3:0]  ovs_r;
  logic [2:0]  maj_r;
  logic        prv_r;
  logic        h1_r;
  logic        h2_r;
  logic [7:0]  shift_r;
  logic [7:0]  txc_cnt_r;
  logic        bit_nxt;
  logic        stb_nxt;
  logic [31:0] rd_nxt;
  serial_cfg_pkg::rx_state_t st_r;
  serial_cfg_pkg::rx_state_t st_nxt;

  // config fields
  wire [2:0] enc = cfg_r[serial_cfg_pkg::ENC_LSB +: 3];
  wire [1:0] eng = cfg_r[serial_cfg_pkg::ENG_LSB +: 2];
  wire       masked_flags_visible = cfg_r[serial_cfg_pkg::VIS_BIT];
  wire       bit_clock_rate_select = cfg_r[serial_cfg_pkg::BCR_BIT];
  wire       tx_clock_output_enable = cfg_r[serial_cfg_pkg::TOE_BIT];

  // address decode
  wire wr_cfg  = wr_en && addr == serial_cfg_pkg::CFG0_OFS;
  wire wr_flag = wr_en && addr == serial_cfg_pkg::FLAG_OFS;
  wire wr_ien  = wr_en && addr == serial_cfg_pkg::IRQ_EN_OFS;
  wire wr_clr  = wr_en && addr == serial_cfg_pkg::IRQ_CLR_OFS;

  // mode decode
  wire enc_ok = enc == serial_cfg_pkg::ENC_NRZ ||
                enc == serial_cfg_pkg::ENC_NRZI ||
                enc == serial_cfg_pkg::ENC_FM0 ||
                enc == serial_cfg_pkg::ENC_FM1 ||
                enc == serial_cfg_pkg::ENC_MAN;
  wire eng_hdlc  = eng == serial_cfg_pkg::ENG_HDLC;
  wire eng_async = eng == serial_cfg_pkg::ENG_ASYNC;
  wire two_half  = enc[2];
  wire dpll_mode = eng_hdlc && two_half;
  wire ovs_mode  = eng_async && bit_clock_rate_select;
  // x16 needs NRZ; any other pairing keeps the receiver quiet
  wire cfg_ok    = enc_ok && (eng_hdlc || eng_async) &&
                   !(ovs_mode && enc != serial_cfg_pkg::ENC_NRZ);

  // link inputs after the synchroniser
  wire rclk_s = sync2_r[0];
  wire rdat_s = sync2_r[1];
  wire txc_s  = sync2_r[2];
  wire rise   = rclk_s && !rclk_d_r;
  wire fall   = !rclk_s && rclk_d_r;

  // majority of the three centre samples
  wire maj = (maj_r[0] & maj_r[1]) | (maj_r[0] & maj_r[2]) |
             (maj_r[1] & maj_r[2]);
  wire ok_cell = cell_ok(enc, h1_r, rdat_s, h2_r);

  // receive state: off, in sync, or hunting after a sync loss
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      serial_cfg_pkg::RX_OFF: begin
        if (cfg_ok) begin
          st_nxt = serial_cfg_pkg::RX_SYNC;
        end
      end
      serial_cfg_pkg::RX_SYNC: begin
        if (!cfg_ok) begin
          st_nxt = serial_cfg_pkg::RX_OFF;
        end else if (dpll_mode && fall && !ok_cell) begin
          st_nxt = serial_cfg_pkg::RX_LOST;
        end
      end
      serial_cfg_pkg::RX_LOST: begin
        if (!cfg_ok || !dpll_mode) begin
          st_nxt = serial_cfg_pkg::RX_OFF;
        end else if (fall && ok_cell) begin
          st_nxt = serial_cfg_pkg::RX_SYNC;
        end
      end
      default: st_nxt = serial_cfg_pkg::RX_OFF;
    endcase
  end

  // bit recovery per clocking mode
  always_comb begin
    bit_nxt = 1'b0;
    stb_nxt = 1'b0;
    if (st_r == serial_cfg_pkg::RX_SYNC && cfg_ok) begin
      if (dpll_mode) begin
        bit_nxt = cell_bit(enc, h1_r, rdat_s);
        stb_nxt = fall && ok_cell;
      end else if (ovs_mode) begin
        bit_nxt = maj;
        stb_nxt = rise && ovs_r == serial_cfg_pkg::OVS_LAST;
      end else if (!two_half) begin
        bit_nxt = line_bit(enc, rdat_s, prv_r);
        stb_nxt = rise;
      end
    end
  end

  // hardware set wins over a software clear in the same cycle
  wire [2:0] ev = {st_r == serial_cfg_pkg::RX_LOST &&
                     st_nxt == serial_cfg_pkg::RX_SYNC,
                   st_r == serial_cfg_pkg::RX_SYNC &&
                     st_nxt == serial_cfg_pkg::RX_LOST,
                   stb_nxt};
  wire [2:0] clr_bits = (wr_clr || wr_flag) ? wr_data[2:0] : 3'h0;
  assign flag_nxt = (flag_r & ~clr_bits) | ev;

  // masked flags hidden unless visibility is on
  wire [2:0] flag_view = masked_flags_visible ? flag_r : (flag_r & en_r);

  // read selection; unmapped offsets read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (addr)
      serial_cfg_pkg::CFG0_OFS:    rd_nxt = cfg_r;
      serial_cfg_pkg::FLAG_OFS:    rd_nxt = {29'h0, flag_view};
      serial_cfg_pkg::IRQ_EN_OFS:  rd_nxt = {29'h0, en_r};
      serial_cfg_pkg::RX_STAT_OFS: begin
        rd_nxt[7:0] = shift_r;
        rd_nxt[serial_cfg_pkg::RST_LOST_BIT] =
          st_r == serial_cfg_pkg::RX_LOST;
        rd_nxt[serial_cfg_pkg::RST_TXC_BIT] = txc_s;
        rd_nxt[serial_cfg_pkg::RST_ACT_BIT] =
          st_r != serial_cfg_pkg::RX_OFF;
      end
      default:                     rd_nxt = 32'h0000_0000;
    endcase
  end

  // configuration register; reserved bits never stored
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_r <= serial_cfg_pkg::CFG0_RST;
    end else if (wr_cfg) begin
      cfg_r <= wr_data & serial_cfg_pkg::CFG0_WMSK;
    end
  end

  // interrupt flags, enables and output
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flag_r <= serial_cfg_pkg::EV_RST;
      en_r   <= serial_cfg_pkg::EV_RST;
      irq    <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      if (wr_ien) begin
        en_r <= wr_data[2:0];
      end
      irq <= |(flag_r & en_r);
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= rd_en ? rd_nxt : 32'h0000_0000;
    end
  end

  // two-stage synchronisers for the line inputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_r  <= 3'h0;
      sync2_r  <= 3'h0;
      rclk_d_r <= 1'b0;
    end else begin
      sync1_r  <= {tx_clk_in, rx_data, rx_clk};
      sync2_r  <= sync1_r;
      rclk_d_r <= rclk_s;
    end
  end

  // receiver sampling registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r  <= serial_cfg_pkg::RX_OFF;
      ovs_r <= 4'h0;
      maj_r <= 3'h0;
      prv_r <= 1'b0;
      h1_r  <= 1'b0;
      h2_r  <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (!ovs_mode) begin
        ovs_r <= 4'h0;
      end else if (rise) begin
        ovs_r <= ovs_r + 4'h1;
      end
      if (rise && ovs_r == serial_cfg_pkg::OVS_TAP0) maj_r[0] <= rdat_s;
      if (rise && ovs_r == serial_cfg_pkg::OVS_TAP1) maj_r[1] <= rdat_s;
      if (rise && ovs_r == serial_cfg_pkg::OVS_TAP2) maj_r[2] <= rdat_s;
      if (rise && !ovs_mode) begin
        prv_r <= rdat_s;
      end
      if (rise) begin
        h1_r <= rdat_s;
      end
      if (fall) begin
        h2_r <= rdat_s;
      end
    end
  end

  // recovered bit outputs and receive shift register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_bit       <= 1'b0;
      rx_bit_valid <= 1'b0;
      shift_r      <= 8'h00;
    end else begin
      rx_bit_valid <= stb_nxt;
      if (stb_nxt) begin
        rx_bit  <= bit_nxt;
        shift_r <= {shift_r[6:0], bit_nxt};
      end
    end
  end

  // transmit clock: divider drives the pin only in the output role
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txc_cnt_r   <= 8'h00;
      tx_clk_out  <= 1'b0;
      tx_clk_oe_n <= 1'b1;
    end else begin
      tx_clk_oe_n <= !tx_clock_output_enable;
      if (!tx_clock_output_enable) begin
        txc_cnt_r  <= 8'h00;
        tx_clk_out <= 1'b0;
      end else if (txc_cnt_r == serial_cfg_pkg::TXC_HALF_CYC - 8'h01) begin
        txc_cnt_r  <= 8'h00;
        tx_clk_out <= !tx_clk_out;
      end else begin
        txc_cnt_r <= txc_cnt_r + 8'h01;
      end
    end
  end

endmodule

/* File: serial_cfg_chk_sva.sv */
`timescale 1ns/1ns
module serial_cfg_chk (
  // system
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rd_data,
  // pin and receive outputs
  input wire logic        tx_clk_out,
  input wire logic        tx_clk_oe_n,
  input wire logic        rx_bit,
  input wire logic        rx_bit_valid,
  input wire logic        irq
);
  logic [2:0] en_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // shadow of the enable register, so masking can be judged at the pin
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      en_r <= 3'h0;
    else if (wr_en && addr == serial_cfg_pkg::IRQ_EN_OFS)
      en_r <= wr_data[2:0];
  end
  // config write and read steps
  sequence wr_cfg;
    wr_en && addr == serial_cfg_pkg::CFG0_OFS;
  endsequence
  sequence rd_cfg;
    rd_en && addr == serial_cfg_pkg::CFG0_OFS;
  endsequence
  chk_cfg_reserved: assert property (rd_cfg |=>
    (rd_data & ~serial_cfg_pkg::CFG0_WMSK) == 32'h0)
    else $error("reserved config bits read nonzero");
  chk_cfg_readback: assert property (wr_cfg ##1 rd_cfg |=>
    rd_data == ($past(wr_data, 2) & serial_cfg_pkg::CFG0_WMSK))
    else $error("config readback differs from write");
  chk_oe_follow: assert property (wr_cfg |-> ##2
    tx_clk_oe_n == !$past(wr_data[serial_cfg_pkg::TOE_BIT], 2))
    else $error("pin direction not set from config");
  chk_pin_quiet: assert property (tx_clk_oe_n [*2] |-> !tx_clk_out)
    else $error("clock driven while pin is input");
  chk_txc_half: assert property ($rose(tx_clk_out) |->
    (tx_clk_out || tx_clk_oe_n) [*4] ##1 (!tx_clk_out || tx_clk_oe_n))
    else $error("transmit clock half period wrong");
  chk_valid_pulse: assert property (rx_bit_valid |=> !rx_bit_valid)
    else $error("bit strobe longer than one cycle");
  chk_bit_hold: assert property (!rx_bit_valid |-> $stable(rx_bit))
    else $error("received bit changed without strobe");
  chk_irq_masked: assert property ($past(en_r) == 3'h0 |-> !irq)
    else $error("interrupt raised while all sources masked");
endmodule
bind serial_channel_config_zero serial_cfg_chk u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .tx_clk_out(tx_clk_out), .tx_clk_oe_n(tx_clk_oe_n), .rx_bit(rx_bit),
  .rx_bit_valid(rx_bit_valid), .irq(irq)
);

/* File: serial_peer.sv */
`timescale 1ns/1ns
module serial_peer (
  // line toward the block
  output logic rx_clk,
  output logic rx_data,
  output logic txc_drv
);
  initial begin
    rx_clk = 1'b0;
    rx_data = 1'b0;
    txc_drv = 1'b0;
  end
  // own transmit clock, used while the block's pin is an input
  always #40 txc_drv = ~txc_drv;
  // msb first, data moves only while clock is low; clock idles between
  // frames and the line flips so a stale level never looks valid
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      rx_data = bits[i];
      #40 rx_clk = 1'b1;
      #40 rx_clk = 1'b0;
    end
    rx_data = ~rx_data;
  endtask
  // two-half cells: first half before the rise, second before the fall;
  // data moves midway between edges so each sample sees a settled level
  task automatic send_cells(input logic [15:0] halves, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      rx_data = halves[2 * i + 1];
      #20 rx_clk = 1'b1;
      #20 rx_data = halves[2 * i];
      #20 rx_clk = 1'b0;
      #20;
    end
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
  typedef struct packed {logic [31:0] w; logic [31:0] r;} row_t;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic [11:0] addr    = 12'h000;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] rd_data, v;
  logic        rx_clk, rx_data, txc_drv, tx_clk_out, tx_clk_oe_n;
  logic        rx_bit, rx_bit_valid, irq;
  wire         tx_clk_in;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  // config writes beside the readback they should give
  row_t rows[11] = '{
    '{32'hFFFF_FFFF, 32'h0073_10A0}, '{32'h0020_0000, 32'h0020_0000},
    '{32'h0040_0000, 32'h0040_0000}, '{32'h0050_0000, 32'h0050_0000},
    '{32'h0060_0000, 32'h0060_0000}, '{32'h0071_0000, 32'h0071_0000},
    '{32'h0002_0000, 32'h0002_0000}, '{32'h0003_1000, 32'h0003_1000},
    '{32'h0008_0080, 32'h0000_0080}, '{32'h0000_4F5F, 32'h0000_0000},
    '{32'h0000_0020, 32'h0000_0020}};
  always #5 clk_sys = ~clk_sys;
  // pin level: block drives when its enable is low, else the peer
  assign tx_clk_in = tx_clk_oe_n ? txc_drv : tx_clk_out;
  serial_peer u_peer (.rx_clk(rx_clk), .rx_data(rx_data), .txc_drv(txc_drv));
  serial_channel_config_zero DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_clk(rx_clk),
    .rx_data(rx_data), .tx_clk_in(tx_clk_in), .tx_clk_out(tx_clk_out),
    .tx_clk_oe_n(tx_clk_oe_n), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .irq(irq));
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // bus tasks end one step past the edge, so strobes never double up
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic conclude();
    $display("checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wt(1);
    rd(serial_cfg_pkg::CFG0_OFS, v);
    `CHK("cfg reset", 32'h0, v)
    `CHK("oe_n reset", 1'b1, tx_clk_oe_n)
    foreach (rows[i]) begin
      wr(serial_cfg_pkg::CFG0_OFS, rows[i].w);
      rd(serial_cfg_pkg::CFG0_OFS, v);
      `CHK("cfg", rows[i].r, v)
    end
    `CHK("oe_n driving", 1'b0, tx_clk_oe_n)
    rd(12'h200, v);
    `CHK("unmapped", 32'h0, v)
    // async x1: one rise per bit, flags masked and hidden
    wr(serial_cfg_pkg::CFG0_OFS, 32'h0003_0000);
    u_peer.send(16'h00A5, 8);
    wt(6);
    rd(serial_cfg_pkg::RX_STAT_OFS, v);
    `CHK("x1 byte", 8'hA5, v[7:0])
    rd(serial_cfg_pkg::FLAG_OFS, v);
    `CHK("hidden flag", 3'h0, v[2:0])
    `CHK("irq masked", 1'b0, irq)
    wr(serial_cfg_pkg::CFG0_OFS, 32'h0003_1000);
    rd(serial_cfg_pkg::FLAG_OFS, v);
    `CHK("shown flag", 3'h1, v[2:0])
    wr(serial_cfg_pkg::FLAG_OFS, 32'h1);
    rd(serial_cfg_pkg::FLAG_OFS, v);
    `CHK("flag cleared", 3'h0, v[2:0])
    wr(serial_cfg_pkg::IRQ_EN_OFS, 32'h7);
    u_peer.send(16'h1, 1);
    wt(6);
    `CHK("irq raised", 1'b1, irq)
    wr(serial_cfg_pkg::IRQ_CLR_OFS, 32'h7);
    wt(2);
    `CHK("irq cleared", 1'b0, irq)
    // x16: one odd sample per bit must be outvoted
    wr(serial_cfg_pkg::CFG0_OFS, 32'h0003_0080);
    u_peer.send(16'hFF7F, 16);
    u_peer.send(16'h0100, 16);
    wt(6);
    rd(serial_cfg_pkg::RX_STAT_OFS, v);
    `CHK("x16 vote", 2'b10, v[1:0])
    // x16 beside a non-NRZ code: receiver stays idle
    wr(serial_cfg_pkg::CFG0_OFS, 32'h0043_0080);
    u_peer.send(16'hFFFF, 16);
    wt(6);
    rd(serial_cfg_pkg::RX_STAT_OFS, v);
    `CHK("x16 fm0 idle", 2'b10, v[1:0])
    // manchester cells: a bad cell loses sync, the next good one regains
    wr(serial_cfg_pkg::CFG0_OFS, 32'h0060_1000);
    wr(serial_cfg_pkg::IRQ_CLR_OFS, 32'h7);
    u_peer.send_cells(16'h000B, 2);
    wt(6);
    rd(serial_cfg_pkg::RX_STAT_OFS, v);
    `CHK("sync lost", 1'b1, v[8])
    rd(serial_cfg_pkg::FLAG_OFS, v);
    `CHK("lost flag", 3'h3, v[2:0])
    u_peer.send_cells(16'h0006, 2);
    wt(6);
    rd(serial_cfg_pkg::RX_STAT_OFS, v);
    `CHK("resync bits", 4'h3, {v[8], v[2:0]})
    rd(serial_cfg_pkg::FLAG_OFS, v);
    `CHK("regain flag", 3'h7, v[2:0])
    // nrzi: a one is a cell with no level change
    wr(serial_cfg_pkg::CFG0_OFS, 32'h0020_0000);
    u_peer.send(16'h0019, 5);
    wt(6);
    rd(serial_cfg_pkg::RX_STAT_OFS, v);
    `CHK("nrzi bits", 4'hA, v[3:0])
    // reserved engine code: the receiver takes nothing
    wr(serial_cfg_pkg::CFG0_OFS, 32'h0001_0000);
    u_peer.send(16'h0001, 1);
    wt(6);
    rd(serial_cfg_pkg::RX_STAT_OFS, v);
    `CHK("reserved eng", 5'h0A, {v[10], v[3:0]})
    // reset in mid-run drops the written fields
    sys_rst <= 1'b1;
    wt(2);
    sys_rst <= 1'b0;
    wt(1);
    rd(serial_cfg_pkg::CFG0_OFS, v);
    `CHK("cfg after reset", 32'h0, v)
    conclude();
  end
endmodule
